// ===== core/dsr_sync.sv
`timescale 1ns/1ps
module dsr_sync #(parameter int W = 8) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule // dsr_sync

// ===== core/dsr_top.sv
// What this block does
// - A 1KB on-chip RAM at 0000h-03ffh, reached only by data moves.
// - The on-chip RAM serves accesses only while its enable bit is one.
// - Reset clears the enable bit; every data move then goes external.
// - With the RAM enabled, addresses above 03ffh use the external bus.
// - With the RAM disabled, its range vanishes; all moves go external.
// - The external data space spans 64 Kbytes with a 16-bit address.
// - Software sets external access length, two to nine machine cycles.
// - A machine cycle lasts four clocks.
// - Port 0 is driven address/data during bus cycles, else open-drain.
// - Port 2 actively drives the upper address byte during bus cycles.
// - Special registers sit at 80h-ffh and answer direct addressing only.
// - Only registers at addresses ending in 0 or 8 take bit operations.
// - Unimplemented register locations and bits read as ones.
// - Scratchpad RAM and on-chip data-move RAM are separate, never aliased.
// - An address strobe pulses so a latch captures the low address.
// - Active-low read and write strobes mark external data transfers.
`timescale 1ns/1ps
module dsr_top
  import dsr_pkg::*;
#(
  parameter int XRAM_BYTES = XRAM_BYTES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data-move request from the core
  input wire logic xm_req,
  input wire logic xm_we,
  input wire logic [ADDR_W-1:0] xm_addr,
  input wire logic [DATA_W-1:0] xm_wdata,
  output logic xm_busy_q,
  output logic xm_done_q,
  output logic [DATA_W-1:0] xm_rdata_q,
  // Register space access from the core
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_indirect,
  input wire logic sfr_bit,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic sfr_bit_val,
  input wire logic [DATA_W-1:0] sfr_wdata,
  output logic sfr_ack_q,
  output logic [DATA_W-1:0] sfr_rdata_q,
  output logic sfr_space_q,
  output logic sfr_bit_refused_q,
  // General-port latches from the port logic
  input wire logic [7:0] p0_latch,
  input wire logic [7:0] p2_latch,
  // Port 0 pins
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out_q,
  output logic [7:0] p0_oe_q,
  // Port 2 pins
  output logic [7:0] p2_out_q,
  output logic [7:0] p2_oe_q,
  // Bus strobes
  output logic addr_strobe_q,
  output logic rd_n_q,
  output logic wr_n_q
);

  localparam int XAW = $clog2(XRAM_BYTES);

  typedef enum {BUS_IDLE, BUS_ADDR, BUS_STROBE, BUS_END} dsr_bus_e;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_onchip(input logic en, input logic [15:0] a);
    return en && (a <= XRAM_LAST);
  endfunction

  function automatic logic [CNT_W-1:0] last_clk(input logic [STR_W-1:0] s);
    return CNT_W'((int'(s) + MC_MIN) * CLKS_PER_MC - 1);
  endfunction

  function automatic logic data_open(input dsr_bus_e st, input logic [CNT_W-1:0] c);
    return (st == BUS_ADDR) && (c == CNT_W'(CLKS_PER_MC - 1));
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] mcr_q;
  logic xen;
  logic [STR_W-1:0] stretch;
  logic direct;
  logic own_hit;
  logic unimpl;
  logic bit_bad;
  logic launch;
  logic go_ram;
  logic go_bus;
  logic bus_done;
  logic [7:0] p0_sync;
  dsr_bus_e bus_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last_q;
  logic bus_we_q;
  logic [7:0] bus_wdata_q;
  logic ram_we_q;

  dsr_mem_if #(.AW(XAW)) ram_if ();

  // ----------------------------------------
  // Register space decode
  // ----------------------------------------
  assign xen = mcr_q[XEN_BIT];
  assign stretch = mcr_q[STR_LSB +: STR_W];
  // Indirect accesses above 7fh go to scratchpad, not here
  assign direct = !sfr_indirect && (sfr_addr >= SFR_BASE);
  assign own_hit = direct && (sfr_addr == MCR_ADDR);
  assign unimpl = direct && !SFR_PRESENT[sfr_addr[6:0]];
  assign bit_bad = sfr_bit && (sfr_addr[2:0] != BIT_ROW_LOW);

  // ----------------------------------------
  // Memory control register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mcr_q <= MCR_RESET;
    end else if (sfr_wr && own_hit && !bit_bad) begin
      if (sfr_bit) begin
        mcr_q[sfr_bit_idx] <= sfr_bit_val & MCR_IMPL_MASK[sfr_bit_idx];
      end else begin
        mcr_q <= sfr_wdata & MCR_IMPL_MASK;
      end
    end
  end

  // ----------------------------------------
  // Register space answer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_ack_q <= 1'b0;
      sfr_rdata_q <= UNIMPL_READ;
      sfr_space_q <= 1'b0;
      sfr_bit_refused_q <= 1'b0;
    end else begin
      sfr_ack_q <= (sfr_rd || sfr_wr) && (own_hit || unimpl) && !bit_bad;
      sfr_space_q <= (sfr_rd || sfr_wr) && direct;
      sfr_bit_refused_q <= (sfr_rd || sfr_wr) && direct && bit_bad;
      if (sfr_rd && own_hit) begin
        sfr_rdata_q <= mcr_q | ~MCR_IMPL_MASK;
      end else if (sfr_rd && unimpl) begin
        sfr_rdata_q <= UNIMPL_READ;
      end
    end
  end

  // ----------------------------------------
  // Data-move routing
  // ----------------------------------------
  // Decode is redone per request so a change of enable is seen at once
  assign launch = xm_req && !xm_busy_q;
  assign go_ram = launch && is_onchip(xen, xm_addr);
  assign go_bus = launch && !is_onchip(xen, xm_addr);
  assign bus_done = (bus_q == BUS_END) && (cnt_q == last_q);

  assign ram_if.req = go_ram;
  assign ram_if.we = xm_we;
  assign ram_if.addr = xm_addr[XAW-1:0];
  assign ram_if.wdata = xm_wdata;

  dsr_xram #(.AW(XAW)) u_xram (
    .clk(clk),
    .reset(reset),
    .port(ram_if)
  );

  dsr_sync #(.W(8)) u_p0_sync (
    .clk(clk),
    .reset(reset),
    .async_in(p0_in),
    .sync_q(p0_sync)
  );

  // Direction of the on-chip access, so a write leaves the read data standing
  always_ff @(posedge clk) begin
    if (reset) begin
      ram_we_q <= 1'b0;
    end else if (go_ram) begin
      ram_we_q <= xm_we;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xm_busy_q <= 1'b0;
    end else if (launch) begin
      xm_busy_q <= 1'b1;
    end else if (ram_if.ack || bus_done) begin
      xm_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xm_done_q <= 1'b0;
      xm_rdata_q <= 8'h00;
    end else begin
      xm_done_q <= ram_if.ack || bus_done;
      if (ram_if.ack && !ram_we_q) begin
        xm_rdata_q <= ram_if.rdata;
      end else if (bus_done && !bus_we_q) begin
        // Synced pin value taken two clocks back, still inside the strobe
        xm_rdata_q <= p0_sync;
      end
    end
  end

  // ----------------------------------------
  // External bus sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_q <= BUS_IDLE;
      cnt_q <= '0;
      last_q <= '0;
      bus_we_q <= 1'b0;
      bus_wdata_q <= 8'h00;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          cnt_q <= '0;
          if (go_bus) begin
            bus_q <= BUS_ADDR;
            last_q <= last_clk(stretch);
            bus_we_q <= xm_we;
            bus_wdata_q <= xm_wdata;
          end
        end
        BUS_ADDR: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CLKS_PER_MC - 1)) begin
            bus_q <= BUS_STROBE;
          end
        end
        BUS_STROBE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == last_q - CNT_W'(1)) begin
            bus_q <= BUS_END;
          end
        end
        BUS_END: begin
          cnt_q <= '0;
          bus_q <= BUS_IDLE;
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_strobe_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      addr_strobe_q <= go_bus ||
        (bus_q == BUS_ADDR && cnt_q < CNT_W'(ALE_CLKS - 1));
      rd_n_q <= !((data_open(bus_q, cnt_q) ||
                   bus_q == BUS_STROBE && cnt_q != last_q - CNT_W'(1))
                  && !bus_we_q);
      wr_n_q <= !((data_open(bus_q, cnt_q) ||
                   bus_q == BUS_STROBE && cnt_q != last_q - CNT_W'(1))
                  && bus_we_q);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      p0_out_q <= 8'h00;
      p0_oe_q <= 8'h00;
      p2_out_q <= 8'hff;
      p2_oe_q <= 8'h00;
    end else if (go_bus) begin
      // Address phase: both ports drive actively
      p0_out_q <= xm_addr[7:0];
      p0_oe_q <= 8'hff;
      p2_out_q <= xm_addr[15:8];
      p2_oe_q <= 8'hff;
    end else if (data_open(bus_q, cnt_q)) begin
      // Data phase: drive for writes, release for reads
      p0_out_q <= bus_wdata_q;
      p0_oe_q <= bus_we_q ? 8'hff : 8'h00;
    end else if (bus_q == BUS_IDLE || bus_done) begin
      // General port: open drain on port 0, only the zeros are driven
      p0_out_q <= 8'h00;
      p0_oe_q <= ~p0_latch;
      p2_out_q <= p2_latch;
      p2_oe_q <= ~p2_latch;
    end
  end

endmodule // dsr_top

// ===== core/dsr_xram.sv
`timescale 1ns/1ps
module dsr_xram #(parameter int AW = 10) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Access port
  dsr_mem_if.mem port
);

  logic [7:0] mem_q [2**AW];

  // Storage keeps no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (port.req && port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      port.rdata <= 8'h00;
      port.ack <= 1'b0;
    end else begin
      port.ack <= port.req;
      if (port.req && !port.we) begin
        port.rdata <= mem_q[port.addr];
      end
    end
  end

endmodule // dsr_xram

// ===== include/dsr_mem_if.sv
`timescale 1ns/1ps
interface dsr_mem_if #(parameter int AW = 10);
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport host (output req, output we, output addr, output wdata,
                input rdata, input ack);
  modport mem (input req, input we, input addr, input wdata,
               output rdata, output ack);
endinterface

// ===== include/dsr_pkg.sv
package dsr_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int XRAM_BYTES_DEF = 1024;

  // ----------------------------------------
  // Memory control register
  // ----------------------------------------
  localparam logic [7:0] MCR_ADDR = 8'hc4;
  localparam int XEN_BIT = 0;
  localparam int STR_LSB = 1;
  localparam int STR_W = 3;
  localparam logic [7:0] MCR_IMPL_MASK = 8'h0f;
  localparam logic [7:0] MCR_RESET = 8'h02;

  // ----------------------------------------
  // Data-move space
  // ----------------------------------------
  localparam logic [15:0] XRAM_LAST = 16'h03ff;

  // ----------------------------------------
  // Bus timing, in clocks; MC_MIN in machine cycles, CNT_W in bits
  // ----------------------------------------
  localparam int CLKS_PER_MC = 4;
  localparam int MC_MIN = 2;
  localparam int ALE_CLKS = 2;
  localparam int CNT_W = 6;

  // ----------------------------------------
  // Special register space
  // ----------------------------------------
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] UNIMPL_READ = 8'hff;
  localparam logic [2:0] BIT_ROW_LOW = 3'h0;
  // One bit per location 80h..ffh, set where a register exists
  localparam logic [127:0] SFR_PRESENT =
    128'h01_01_01_01_7f_01_ff_b8_03_0f_fb_27_bf_fd_7f_8f;

endpackage

// ===== testbench/dsr_checker_assertions.sv
`timescale 1ns/1ps
module dsr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Core side
  input wire logic xm_busy_q,
  input wire logic xm_done_q,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_indirect,
  input wire logic sfr_bit,
  input wire logic sfr_ack_q,
  input wire logic sfr_space_q,
  input wire logic sfr_bit_refused_q,
  // Bus side
  input wire logic [7:0] p0_oe_q,
  input wire logic [7:0] p2_oe_q,
  input wire logic addr_strobe_q,
  input wire logic rd_n_q,
  input wire logic wr_n_q
);
  // ----------------------------------------
  // Bus and register-space checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic acc = (sfr_rd || sfr_wr) && !sfr_indirect && sfr_addr[7];

  done_bound_a: assert property ($rose(xm_busy_q) |-> ##[1:37] xm_done_q)
    else $error("access too long");
  ale_width_a: assert property ($rose(addr_strobe_q) |=> addr_strobe_q ##1 !addr_strobe_q)
    else $error("bad strobe width");
  rd_len_a: assert property ($fell(rd_n_q) |-> !rd_n_q [*3])
    else $error("read strobe short");
  strobe_excl_a: assert property (!rd_n_q |-> wr_n_q && !addr_strobe_q)
    else $error("strobes overlap");
  rd_release_a: assert property (!rd_n_q |-> p0_oe_q == 8'h00 && p2_oe_q == 8'hff)
    else $error("bad drive on read");
  wr_drive_a: assert property (!wr_n_q || addr_strobe_q |-> p0_oe_q == 8'hff && p2_oe_q == 8'hff)
    else $error("bad drive");
  space_hit_a: assert property (acc |=> sfr_space_q)
    else $error("space missed");
  scratch_only_a: assert property ((sfr_rd || sfr_wr) && !acc |=> !sfr_space_q && !sfr_ack_q)
    else $error("scratch answered");
  bit_refuse_a: assert property (acc && sfr_bit && sfr_addr[2:0] != 3'h0 |=> sfr_bit_refused_q && !sfr_ack_q)
    else $error("bit op taken");
endmodule // dsr_checker

bind dsr_top dsr_checker u_chk (.clk, .reset, .xm_busy_q, .xm_done_q, .sfr_rd, .sfr_wr,
  .sfr_addr, .sfr_indirect, .sfr_bit, .sfr_ack_q, .sfr_space_q, .sfr_bit_refused_q,
  .p0_oe_q, .p2_oe_q, .addr_strobe_q, .rd_n_q, .wr_n_q);

// ===== testbench/dsr_ext_mem.sv
`timescale 1ns/1ps
module dsr_ext_mem (
  // Clock and pacing
  input wire logic clk,
  input wire logic [3:0] lat,
  // Bus from the device
  input wire logic [7:0] p0_out_q,
  input wire logic [7:0] p0_oe_q,
  input wire logic [7:0] p2_out_q,
  input wire logic addr_strobe_q,
  input wire logic rd_n_q,
  input wire logic wr_n_q,
  // Resolved port 0 level
  output logic [7:0] p0_pin
);
  // ----------------------------------------
  // Latched-address memory
  // ----------------------------------------
  logic [7:0] mem [logic [15:0]];
  logic [15:0] addr_q;
  logic [7:0] last_q = 8'h00;
  logic [7:0] drv;
  int wait_q;
  always @(posedge clk) begin
    if (addr_strobe_q) addr_q <= {p2_out_q, p0_out_q};
    if (!wr_n_q) mem[addr_q] = p0_out_q;
    wait_q <= rd_n_q ? 0 : wait_q + 1;
    last_q <= drv;
  end
  // Released or not yet ready: a toggling pattern, so stale data never looks valid
  always_comb begin
    if (rd_n_q || wait_q < lat) drv = ~last_q;
    else drv = mem.exists(addr_q) ? mem[addr_q] : 8'h5a;
  end
  assign p0_pin = (p0_oe_q & p0_out_q) | (~p0_oe_q & drv);
endmodule // dsr_ext_mem

// ===== testbench/tb_data_space_router.sv
`timescale 1ns/1ps
module tb_data_space_router;
  import dsr_pkg::*;
  logic clk, reset, xm_req, xm_we, sfr_rd, sfr_wr, sfr_indirect, sfr_bit, sfr_bit_val;
  logic xm_busy_q, xm_done_q, sfr_ack_q, sfr_space_q, sfr_bit_refused_q, addr_strobe_q;
  logic rd_n_q, wr_n_q;
  logic [15:0] xm_addr, a;
  logic [7:0] xm_wdata, sfr_addr, sfr_wdata, p0_latch, p2_latch, p0_pin, d1;
  logic [7:0] xm_rdata_q, sfr_rdata_q, p0_out_q, p0_oe_q, p2_out_q, p2_oe_q;
  logic [2:0] sfr_bit_idx;
  logic [3:0] lat;
  logic [8:0] e;
  logic [8:0] xq[$], sq[$];
  int mismatches, check_count, cyc, ale_n, ticks, n;

  dsr_top DUT (.clk, .reset, .xm_req, .xm_we, .xm_addr, .xm_wdata, .xm_busy_q, .xm_done_q,
    .xm_rdata_q, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_indirect, .sfr_bit, .sfr_bit_idx,
    .sfr_bit_val, .sfr_wdata, .sfr_ack_q, .sfr_rdata_q, .sfr_space_q, .sfr_bit_refused_q,
    .p0_latch, .p2_latch, .p0_in(p0_pin), .p0_out_q, .p0_oe_q, .p2_out_q, .p2_oe_q,
    .addr_strobe_q, .rd_n_q, .wr_n_q);
  dsr_ext_mem ext (.clk, .lat, .p0_out_q, .p0_oe_q, .p2_out_q, .addr_strobe_q, .rd_n_q,
    .wr_n_q, .p0_pin);

  // ----------------------------------------
  // Clock, tasks and result watcher
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic xm(input logic we, input logic [15:0] ad, input logic [7:0] d);
    xq.push_back({!we, d});
    xm_req = 1;
    xm_we = we;
    xm_addr = ad;
    xm_wdata = d;
    @(negedge clk);
    xm_req = 0;
    cyc = 1;
    while (!xm_done_q && cyc < 60) begin
      @(negedge clk);
      cyc++;
    end
  endtask

  // Only answered accesses leave a note, so refused ones cannot steal a result
  task automatic special_register_space(input logic wr, input logic [7:0] ad, input logic [7:0] d,
                     input logic ind, input logic bt, input logic [9:0] ex);
    if (ex[9]) sq.push_back(ex[8:0]);
    sfr_rd = !wr;
    sfr_wr = wr;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_indirect = ind;
    sfr_bit = bt;
    @(negedge clk);
    sfr_rd = 0;
    sfr_wr = 0;
    @(negedge clk);
  endtask

  always @(negedge clk) begin
    ticks++;
    if (addr_strobe_q || !rd_n_q || !wr_n_q) ale_n++;
    if (xm_done_q && xq.size() > 0) begin
      e = xq.pop_front();
      if (e[8]) chk(xm_rdata_q, e[7:0]);
    end
    if (sfr_ack_q && sq.size() > 0) begin
      e = sq.pop_front();
      if (e[8]) chk(sfr_rdata_q, e[7:0]);
    end
    if (ticks == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    n = $urandom(48250);
    {xm_req, xm_we, xm_addr, xm_wdata, sfr_rd, sfr_wr, sfr_addr, sfr_wdata} = '0;
    {sfr_indirect, sfr_bit, sfr_bit_idx, sfr_bit_val, lat} = '0;
    p0_latch = 8'($urandom);
    p2_latch = 8'($urandom);
    reset = 1;
    repeat (5) @(negedge clk);
    reset = 0;
    special_register_space(0, MCR_ADDR, 8'h00, 0, 0, 10'h3f2);
    special_register_space(0, 8'hc1, 8'h00, 0, 0, 10'h3ff);
    special_register_space(0, MCR_ADDR, 8'h00, 1, 0, 10'h000);
    for (int s = 0; s < 8; s++) begin
      a = 16'($urandom);
      d1 = 8'($urandom);
      lat = 4'(s);
      special_register_space(1, MCR_ADDR, 8'(s << 1), 0, 0, 10'h200);
      xm(1, a, d1);
      chk(8'(cyc), 8'((s + 2) * 4 + 1));
      xm(0, a, d1);
      chk(8'(cyc), 8'((s + 2) * 4 + 1));
    end
    lat = 0;
    xm(1, 16'h0010, 8'h3c);
    special_register_space(1, MCR_ADDR, 8'h01, 0, 0, 10'h200);
    special_register_space(1, MCR_ADDR, 8'h00, 0, 1, 10'h000);
    special_register_space(0, MCR_ADDR, 8'h00, 0, 0, 10'h3f1);
    n = ale_n;
    xm(1, 16'h0010, 8'hc3);
    chk(xm_rdata_q, d1);
    xm(0, 16'h0010, 8'hc3);
    chk(8'(cyc), 8'h02);
    xm(1, 16'h03ff, 8'ha5);
    xm(0, 16'h03ff, 8'ha5);
    chk(8'(ale_n - n), 8'h00);
    xm(1, 16'h8010, 8'h69);
    xm(1, 16'h0400, 8'h96);
    xm(0, 16'h8010, 8'h69);
    xm(0, 16'h0400, 8'h96);
    chk(8'(cyc), 8'h09);
    xm(0, 16'h0010, 8'hc3);
    special_register_space(1, MCR_ADDR, 8'h00, 0, 0, 10'h200);
    xm(0, 16'h0010, 8'h3c);
    repeat (4) @(negedge clk);
    chk(p0_oe_q, ~p0_latch);
    chk(p2_out_q, p2_latch);
    summarize();
  end
endmodule // tb_data_space_router
